//--- dv/mcu_instruction_decoder_tb.sv
`default_nettype none
module mcu_instruction_decoder_tb import mcudec_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic CLK_IN = 1'b0;
    logic RESETN_IN = 1'b0;
    logic [3:0] REG_ADDR_IN = 4'h0;
    logic [7:0] REG_WDATA_IN = 8'h00;
    logic REG_WR_IN = 1'b0;
    logic REG_RD_IN = 1'b0;
    logic [20:0] PMEM_ADDR_OUT;
    logic [15:0] INSTR_IN;
    logic [11:0] FILE_ADDR_OUT;
    logic [7:0] FILE_RDATA_IN;
    logic [7:0] FILE_WDATA_OUT;
    logic FILE_WE_OUT;
    logic [20:0] TABLE_PTR_OUT;
    logic CYCLE_END_OUT;
    logic [7:0] REG_RDATA_OUT;
    int bad_count = 0;
    int tests_run = 0;
    // Skipped words set bits of 0x018 or move into 0x030, so any wrong skip shows there
    logic [15:0] code [0:31] = '{
        16'h0000, 16'h0E05, 16'h3E10, 16'h8018, 16'h4C11, 16'h0E05, 16'h6213, 16'hC020,
        16'hF030, 16'h6512, 16'h8218, 16'h6014, 16'h8418, 16'h2F12, 16'h8615, 16'h9E16,
        16'hC020, 16'hF031, 16'hF123, 16'hD001, 16'h8618, 16'h0E11, 16'hED28, 16'hF000,
        16'h0E44, 16'hEC2C, 16'hF000, 16'h0217, 16'hEC30, 16'hF000, 16'hEF1E, 16'hF000};

    mcudec_core dut (.CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN), .PMEM_ADDR_OUT(PMEM_ADDR_OUT),
        .INSTR_IN(INSTR_IN), .FILE_ADDR_OUT(FILE_ADDR_OUT), .FILE_RDATA_IN(FILE_RDATA_IN),
        .FILE_WDATA_OUT(FILE_WDATA_OUT), .FILE_WE_OUT(FILE_WE_OUT),
        .TABLE_PTR_OUT(TABLE_PTR_OUT), .CYCLE_END_OUT(CYCLE_END_OUT),
        .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN),
        .REG_RD_IN(REG_RD_IN), .REG_RDATA_OUT(REG_RDATA_OUT));
    mcudec_mem_model mem (.clk_in(CLK_IN), .pmem_addr_in(PMEM_ADDR_OUT), .instr_out(INSTR_IN),
        .file_addr_in(FILE_ADDR_OUT), .file_wdata_in(FILE_WDATA_OUT),
        .file_we_in(FILE_WE_OUT), .file_rdata_out(FILE_RDATA_IN));

    // 250 MHz core clock
    always #2 CLK_IN = ~CLK_IN;

    task automatic check(input string what, input logic [20:0] seen, input logic [20:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Register port: one-cycle strobes, read data sampled in the following cycle
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge CLK_IN);
        REG_ADDR_IN <= a;
        REG_WDATA_IN <= d;
        REG_WR_IN <= 1'b1;
        @(posedge CLK_IN);
        REG_WR_IN <= 1'b0;
    endtask

    task automatic rd_check(input logic [3:0] a, input logic [7:0] exp, input string what);
        logic [7:0] d;
        @(posedge CLK_IN);
        REG_ADDR_IN <= a;
        REG_RD_IN <= 1'b1;
        @(posedge CLK_IN);
        REG_RD_IN <= 1'b0;
        #1 d = REG_RDATA_OUT;
        check(what, {13'h0, d}, {13'h0, exp});
    endtask

    task automatic fchk(input logic [11:0] a, input logic [7:0] exp, input string what);
        check(what, {13'h0, mem.fmem[a]}, {13'h0, exp});
    endtask

    // Status shows only the flush flag: the first word after reset is discarded
    task automatic test_reset_regs();
        for (int a = 0; a < 16; a++) begin
            rd_check(4'(a), (a == 9) ? 8'h04 : 8'h00, "reset or unmapped register");
        end
        $display("test reset_regs done");
    endtask

    task automatic test_pointer();
        reg_wr(REG_PTR_LOW, 8'hA5);
        reg_wr(REG_PTR_UPPER, 8'hFF);
        reg_wr(REG_LATCH, 8'h5A);
        rd_check(REG_PTR_UPPER, 8'h1F, "pointer upper");
        rd_check(REG_LATCH, 8'h5A, "latch");
        check("pointer out", TABLE_PTR_OUT, 21'h1F00A5);
        $display("test pointer done");
    endtask

    // One program covers skips, moves, branch, calls and fast returns
    task automatic test_program();
        int n;
        int cycles;
        for (int i = 0; i < 32; i++) begin
            mem.prog[i] = code[i];
        end
        mem.prog[40] = 16'h0E22;
        mem.prog[41] = 16'h0013;
        mem.prog[44] = 16'h0E33;
        mem.prog[45] = 16'h0013;
        mem.prog[48] = 16'h2E19;
        mem.prog[49] = 16'h8018;
        mem.prog[50] = 16'h4E1A;
        mem.prog[51] = 16'h8218;
        mem.prog[52] = 16'h0E55;
        mem.prog[53] = 16'h0012;
        mem.fmem[12'h010] = 8'hFF;
        mem.fmem[12'h011] = 8'h01;
        mem.fmem[12'h212] = 8'h07;
        mem.fmem[12'h013] = 8'h05;
        mem.fmem[12'h014] = 8'h01;
        mem.fmem[12'h016] = 8'hFF;
        mem.fmem[12'h017] = 8'h20;
        mem.fmem[12'h020] = 8'h3C;
        mem.fmem[12'h019] = 8'h01;
        mem.fmem[12'h01A] = 8'h02;
        reg_wr(REG_BANK, 8'h02);
        reg_wr(REG_CTRL, 8'h01);
        // Falling-edge sampling sees settled outputs; count instruction cycles
        cycles = 0;
        for (n = 0; n < 1000 && PMEM_ADDR_OUT !== 21'h00003C; n++) begin
            @(negedge CLK_IN);
            if (CYCLE_END_OUT === 1'b1) begin
                cycles++;
            end
        end
        if (n == 1000) begin
            bad_count++;
            $display("mismatch program end expected reached seen hung");
        end else begin
            check("instruction cycles", 21'(cycles), 21'h00002B);
            repeat (40) @(posedge CLK_IN);
            fchk(12'h010, 8'h00, "inc skip result");
            fchk(12'h011, 8'h01, "dec to accumulator");
            fchk(12'h212, 8'h06, "banked dec");
            fchk(12'h015, 8'h08, "bit set");
            fchk(12'h016, 8'h7F, "bit clear");
            fchk(12'h018, 8'h00, "skipped words");
            fchk(12'h030, 8'h00, "skipped move");
            fchk(12'h031, 8'h3C, "move");
            rd_check(REG_PROD_LOW, 8'h20, "product low");
            rd_check(REG_PROD_HIGH, 8'h02, "product high");
            rd_check(REG_ACC, 8'h55, "accumulator");
            fchk(12'h019, 8'h00, "dec skip zero");
            fchk(12'h01A, 8'h01, "dec skip nonzero");
        end
        $display("test program done");
    endtask

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge CLK_IN);
        RESETN_IN <= 1'b1;
        test_reset_regs();
        test_pointer();
        test_program();
        report_and_stop();
    end
endmodule
`default_nettype wire

//--- dv/mcudec_core_props.sv
`default_nettype none
module mcudec_core_props import mcudec_pkg::*; (
    input wire logic CLK_IN,
    input wire logic RESETN_IN,
    input wire logic [20:0] PMEM_ADDR_OUT,
    input wire logic [11:0] FILE_ADDR_OUT,
    input wire logic FILE_WE_OUT,
    input wire logic [20:0] TABLE_PTR_OUT,
    input wire logic CYCLE_END_OUT,
    input wire logic [3:0] REG_ADDR_IN,
    input wire logic [7:0] REG_WDATA_IN,
    input wire logic REG_WR_IN
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RESETN_IN);

    // Instruction cycle framing and pipeline hold times
    chk_cycle_gap: assert property (CYCLE_END_OUT |=> !CYCLE_END_OUT [*3])
        else $error("cycle end came early");
    chk_cycle_next: assert property (CYCLE_END_OUT |-> ##4 CYCLE_END_OUT)
        else $error("cycle end missing after four clocks");
    chk_pc_hold: assert property (!CYCLE_END_OUT |=> $stable(PMEM_ADDR_OUT))
        else $error("fetch address moved inside a cycle");
    chk_pc_even: assert property (PMEM_ADDR_OUT[0] == 1'b0)
        else $error("fetch address is odd");
    // Write pulse lands just after a cycle end, address still held
    chk_we_after_end: assert property (FILE_WE_OUT |-> $past(CYCLE_END_OUT))
        else $error("file write outside phase zero");
    chk_we_single: assert property (FILE_WE_OUT |=> !FILE_WE_OUT)
        else $error("file write longer than one clock");
    chk_faddr_hold: assert property (CYCLE_END_OUT |=> $stable(FILE_ADDR_OUT))
        else $error("file address changed under the write");
    // Pointer bytes land where software put them, upper bits cut to 21
    chk_ptr_low_byte: assert property (REG_WR_IN && REG_ADDR_IN == REG_PTR_LOW
        |=> TABLE_PTR_OUT[7:0] == $past(REG_WDATA_IN)) else $error("pointer low byte lost");
    chk_ptr_upper_bits: assert property (REG_WR_IN && REG_ADDR_IN == REG_PTR_UPPER
        |=> {3'h0, TABLE_PTR_OUT[20:16]} == ($past(REG_WDATA_IN) & 8'h1F))
        else $error("pointer upper bits wrong");
endmodule
bind mcudec_core mcudec_core_props u_props (.CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN),
    .PMEM_ADDR_OUT(PMEM_ADDR_OUT), .FILE_ADDR_OUT(FILE_ADDR_OUT), .FILE_WE_OUT(FILE_WE_OUT),
    .TABLE_PTR_OUT(TABLE_PTR_OUT), .CYCLE_END_OUT(CYCLE_END_OUT),
    .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN));
`default_nettype wire

//--- dv/mcudec_mem_model.sv
`default_nettype none
module mcudec_mem_model (
    input wire logic clk_in,
    input wire logic [20:0] pmem_addr_in,
    output logic [15:0] instr_out,
    input wire logic [11:0] file_addr_in,
    input wire logic [7:0] file_wdata_in,
    input wire logic file_we_in,
    output logic [7:0] file_rdata_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] prog [0:255];
    logic [7:0] fmem [0:4095];

    // Blank memory holds no-operation words and zero data
    initial begin
        for (int i = 0; i < 4096; i++) begin
            fmem[i] = 8'h00;
            if (i < 256) begin
                prog[i] = 16'h0000;
            end
        end
    end

    // Reads are immediate, so the word is settled long before phase 3 ends
    assign instr_out = (pmem_addr_in[20:9] == 12'h000) ? prog[pmem_addr_in[8:1]] : 16'h0000;
    assign file_rdata_out = fmem[file_addr_in];

    // File write taken on the clock of the pulse
    always @(posedge clk_in) begin
        if (file_we_in) begin
            fmem[file_addr_in] <= file_wdata_in;
        end
    end
endmodule
`default_nettype wire

//--- logic/mcudec_alu.sv
`default_nettype none
module mcudec_alu (
    input wire mcudec_pkg::mcudec_op_e op_in,
    input wire logic [7:0] file_in,
    input wire logic [7:0] acc_in,
    input wire logic [2:0] bit_in,
    output logic [7:0] result_out,
    output logic skip_out
);
    import mcudec_pkg::*;

    logic [7:0] mask;

    // Skip ops touch no status flags: only result and skip leave here
    always_comb begin
        mask = 8'h01 << bit_in;
        result_out = file_in;
        skip_out = 1'b0;
        case (op_in)
            OP_CMP_EQ: skip_out = (file_in == acc_in);
            OP_CMP_GT: skip_out = (file_in > acc_in);
            OP_CMP_LT: skip_out = (file_in < acc_in);
            OP_DEC_Z: begin
                result_out = file_in - 8'h01;
                skip_out = (result_out == 8'h00);
            end
            OP_DEC_NZ: begin
                result_out = file_in - 8'h01;
                skip_out = (result_out != 8'h00);
            end
            OP_INC_Z: begin
                result_out = file_in + 8'h01;
                skip_out = (result_out == 8'h00);
            end
            OP_BIT_SET: result_out = file_in | mask;
            OP_BIT_CLR: result_out = file_in & ~mask;
            default: result_out = file_in;
        endcase
    end
endmodule
`default_nettype wire

//--- logic/mcudec_core.sv
// Implementation choices: the address map and the strobed register port.
`default_nettype none
module mcudec_core (
    input wire logic CLK_IN,
    input wire logic RESETN_IN,
    output logic [20:0] PMEM_ADDR_OUT,
    input wire logic [15:0] INSTR_IN,
    output logic [11:0] FILE_ADDR_OUT,
    input wire logic [7:0] FILE_RDATA_IN,
    output logic [7:0] FILE_WDATA_OUT,
    output logic FILE_WE_OUT,
    output logic [20:0] TABLE_PTR_OUT,
    output logic CYCLE_END_OUT,
    input wire logic [3:0] REG_ADDR_IN,
    input wire logic [7:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    output logic [7:0] REG_RDATA_OUT
);
    import mcudec_pkg::*;

    typedef struct packed {
        logic [1:0] phase;
        logic [20:0] pc;
        logic [15:0] ir;
        logic flush;
        logic move_pend;
        logic [7:0] move_data;
        logic [11:0] faddr;
        logic [7:0] fdata;
        logic fwe;
        logic [7:0] fwdata;
        logic [7:0] acc;
        logic [7:0] bank;
        logic [7:0] prod_high;
        logic [7:0] prod_low;
        logic [20:0] tptr;
        logic [7:0] tlatch;
        logic run;
        logic [7:0] shadow_acc;
        logic [7:0] shadow_bank;
        logic [7:0] rdata;
    } mcudec_core_s;

    mcudec_core_s s_q;
    mcudec_core_s s_d;
    mcudec_op_e op;
    logic [7:0] alu_result;
    logic alu_skip;
    logic push;
    logic pop;
    logic [20:0] stack_top;
    logic [15:0] product;

    // Effective file address for byte and bit forms
    function automatic logic [11:0] bank_addr(input logic [15:0] w, input logic [7:0] bank_selector);
        if (w[ACCESS_BIT]) begin
            bank_addr = {bank_selector[3:0], w[7:0]};
        end else if (w[7:0] < ACCESS_SPLIT) begin
            bank_addr = {4'h0, w[7:0]};
        end else begin
            bank_addr = {ACCESS_HIGH_BANK, w[7:0]};
        end
    endfunction

    // Opcode decode; bits not matched here are ignored entirely
    function automatic mcudec_op_e decode(input logic [15:0] w);
        decode = OP_NOP;
        case (w[15:12])
            4'h0: begin
                if (w[11:8] == 4'hE) begin
                    decode = OP_LIT;
                end else if (w[11:9] == 3'b001) begin
                    decode = OP_MUL;
                end else if (w[11:1] == 11'h009) begin
                    decode = OP_RET;
                end
            end
            4'h2: decode = (w[11:10] == 2'b11) ? OP_DEC_Z : OP_NOP;
            4'h3: decode = (w[11:10] == 2'b11) ? OP_INC_Z : OP_NOP;
            4'h4: decode = (w[11:10] == 2'b11) ? OP_DEC_NZ : OP_NOP;
            4'h6: begin
                case (w[11:9])
                    3'b000: decode = OP_CMP_LT;
                    3'b001: decode = OP_CMP_EQ;
                    3'b010: decode = OP_CMP_GT;
                    default: decode = OP_NOP;
                endcase
            end
            4'h8: decode = OP_BIT_SET;
            4'h9: decode = OP_BIT_CLR;
            4'hC: decode = OP_MOVE;
            4'hD: decode = w[11] ? OP_NOP : OP_BRA;
            4'hE: begin
                if (w[11:8] == 4'hF) begin
                    decode = OP_GOTO;
                end else if (w[11:9] == 3'b110) begin
                    decode = OP_CALL;
                end
            end
            default: decode = OP_NOP;
        endcase
    endfunction

    // A flushed word becomes a no-operation cycle
    assign op = s_q.flush ? OP_NOP : decode(s_q.ir);

    // Skip and result logic for the byte and bit forms
    mcudec_alu u_alu (
        .op_in(op),
        .file_in(s_q.fdata),
        .acc_in(s_q.acc),
        .bit_in(s_q.ir[11:9]),
        .result_out(alu_result),
        .skip_out(alu_skip)
    );

    // Return stack, eight entries deep; overflow wraps without warning
    mcudec_stack u_stack (
        .clk_in(CLK_IN),
        .resetn_in(RESETN_IN),
        .push_in(push),
        .pop_in(pop),
        .push_data_in(s_q.pc + 21'h000002),
        .top_out(stack_top)
    );

    // Unsigned 8 by 8 product, kept whole so neither byte is lost
    assign product = s_q.acc * s_q.fdata;

    // Phase, operand fetch, execute and software register access
    always_comb begin
        logic exec;
        logic redirect;
        exec = 1'b0;
        redirect = 1'b0;
        s_d = s_q;
        push = 1'b0;
        pop = 1'b0;
        s_d.fwe = 1'b0;
        if (s_q.run) begin
            s_d.phase = s_q.phase + 2'h1;
            exec = (s_q.phase == PHASE_LAST);
        end
        // Operand address is set after the write slot of the previous cycle
        if (s_q.run && s_q.phase == PHASE_FIRST) begin
            if (s_q.move_pend && s_q.ir[15:12] == SECOND_WORD_TAG) begin
                s_d.faddr = s_q.ir[11:0];
            end else if (s_q.ir[15:12] == 4'hC) begin
                s_d.faddr = s_q.ir[11:0];
            end else begin
                s_d.faddr = bank_addr(s_q.ir, s_q.bank);
            end
        end
        if (s_q.run && s_q.phase == PHASE_SAMPLE) begin
            s_d.fdata = FILE_RDATA_IN;
        end
        if (exec) begin
            s_d.move_pend = 1'b0;
            case (op)
                OP_LIT: s_d.acc = s_q.ir[7:0];
                OP_DEC_Z, OP_DEC_NZ, OP_INC_Z: begin
                    if (s_q.ir[DEST_BIT]) begin
                        s_d.fwe = 1'b1;
                        s_d.fwdata = alu_result;
                    end else begin
                        s_d.acc = alu_result;
                    end
                end
                OP_BIT_SET, OP_BIT_CLR: begin
                    s_d.fwe = 1'b1;
                    s_d.fwdata = alu_result;
                end
                OP_MUL: begin
                    s_d.prod_high = product[15:8];
                    s_d.prod_low = product[7:0];
                end
                OP_MOVE: begin
                    s_d.move_data = s_q.fdata;
                    s_d.move_pend = 1'b1;
                end
                OP_GOTO: begin
                    s_d.pc = {INSTR_IN[11:0], s_q.ir[7:0], 1'b0};
                    redirect = 1'b1;
                end
                OP_CALL: begin
                    s_d.pc = {INSTR_IN[11:0], s_q.ir[7:0], 1'b0};
                    push = 1'b1;
                    redirect = 1'b1;
                    if (s_q.ir[CALL_FAST_BIT]) begin
                        s_d.shadow_acc = s_q.acc;
                        s_d.shadow_bank = s_q.bank;
                    end else begin
                        // Fast bit clear: shadow copies keep what they hold
                        s_d.shadow_acc = s_q.shadow_acc;
                        s_d.shadow_bank = s_q.shadow_bank;
                    end
                end
                OP_RET: begin
                    s_d.pc = stack_top;
                    pop = 1'b1;
                    redirect = 1'b1;
                    if (s_q.ir[FAST_BIT]) begin
                        s_d.acc = s_q.shadow_acc;
                        s_d.bank = s_q.shadow_bank;
                    end else begin
                        // Fast bit clear: nothing comes back from the shadows
                        s_d.acc = s_q.acc;
                        s_d.bank = s_q.bank;
                    end
                end
                OP_BRA: begin
                    s_d.pc = s_q.pc + {{9{s_q.ir[10]}}, s_q.ir[10:0], 1'b0};
                    redirect = 1'b1;
                end
                default: begin
                    // Lone second word: complete a pending move, else nothing
                    if (s_q.move_pend && !s_q.flush) begin
                        s_d.fwe = 1'b1;
                        s_d.fwdata = s_q.move_data;
                    end
                end
            endcase
            // Straight-line flow steps to the next word
            if (!redirect) begin
                s_d.pc = s_q.pc + 21'h000002;
            end
            s_d.ir = INSTR_IN;
            s_d.flush = redirect || alu_skip;
        end
        // Software access wins over a same-cycle core update
        if (REG_WR_IN) begin
            case (REG_ADDR_IN)
                REG_ACC: s_d.acc = REG_WDATA_IN;
                REG_BANK: s_d.bank = REG_WDATA_IN;
                REG_PROD_LOW: s_d.prod_low = REG_WDATA_IN;
                REG_PROD_HIGH: s_d.prod_high = REG_WDATA_IN;
                REG_PTR_LOW: s_d.tptr[7:0] = REG_WDATA_IN;
                REG_PTR_HIGH: s_d.tptr[15:8] = REG_WDATA_IN;
                REG_PTR_UPPER: s_d.tptr[20:16] = REG_WDATA_IN[4:0];
                REG_LATCH: s_d.tlatch = REG_WDATA_IN;
                REG_CTRL: s_d.run = REG_WDATA_IN[0];
                default: s_d.run = s_q.run;
            endcase
        end
        s_d.rdata = BYTE_RESET;
        if (REG_RD_IN) begin
            case (REG_ADDR_IN)
                REG_ACC: s_d.rdata = s_q.acc;
                REG_BANK: s_d.rdata = s_q.bank;
                REG_PROD_LOW: s_d.rdata = s_q.prod_low;
                REG_PROD_HIGH: s_d.rdata = s_q.prod_high;
                REG_PTR_LOW: s_d.rdata = s_q.tptr[7:0];
                REG_PTR_HIGH: s_d.rdata = s_q.tptr[15:8];
                REG_PTR_UPPER: s_d.rdata = {3'h0, s_q.tptr[20:16]};
                REG_LATCH: s_d.rdata = s_q.tlatch;
                REG_CTRL: s_d.rdata = {7'h00, s_q.run};
                REG_STATUS: s_d.rdata = {4'h0, s_q.move_pend, s_q.flush, s_q.phase};
                default: s_d.rdata = BYTE_RESET;
            endcase
        end
    end

    // Reset starts with a flushed word so stale memory data never executes
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            s_q <= '0;
            s_q.pc <= PC_RESET;
            s_q.flush <= 1'b1;
            s_q.run <= CTRL_RUN_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // Every output but the cycle marker comes straight from a register
    assign PMEM_ADDR_OUT = s_q.pc;
    assign FILE_ADDR_OUT = s_q.faddr;
    assign FILE_WDATA_OUT = s_q.fwdata;
    assign FILE_WE_OUT = s_q.fwe;
    assign TABLE_PTR_OUT = s_q.tptr;
    assign CYCLE_END_OUT = s_q.run && (s_q.phase == PHASE_LAST);
    assign REG_RDATA_OUT = s_q.rdata;
endmodule
`default_nettype wire

//--- logic/mcudec_pkg.sv
`default_nettype none
package mcudec_pkg;
    // Instruction cycle timing: four clocks stand for four oscillator periods
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned OSC_PER_CYCLE = 4;
    localparam logic [1:0] PHASE_FIRST = 2'h0;
    localparam logic [1:0] PHASE_SAMPLE = 2'h2;
    localparam logic [1:0] PHASE_LAST = 2'(OSC_PER_CYCLE - 1);

    // Widths
    localparam int unsigned PTR_W = 21;
    localparam int unsigned FADDR_W = 12;
    localparam int unsigned STACK_DEPTH = 8;

    // Register port offsets
    localparam logic [3:0] REG_ACC = 4'h0;
    localparam logic [3:0] REG_BANK = 4'h1;
    localparam logic [3:0] REG_PROD_LOW = 4'h2;
    localparam logic [3:0] REG_PROD_HIGH = 4'h3;
    localparam logic [3:0] REG_PTR_LOW = 4'h4;
    localparam logic [3:0] REG_PTR_HIGH = 4'h5;
    localparam logic [3:0] REG_PTR_UPPER = 4'h6;
    localparam logic [3:0] REG_LATCH = 4'h7;
    localparam logic [3:0] REG_CTRL = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'h9;

    // Field positions
    localparam int unsigned DEST_BIT = 9;
    localparam int unsigned ACCESS_BIT = 8;
    localparam int unsigned FAST_BIT = 0;
    localparam int unsigned CALL_FAST_BIT = 8;
    localparam logic [3:0] SECOND_WORD_TAG = 4'hF;
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

    // Reset values
    localparam logic [20:0] PC_RESET = 21'h000000;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic CTRL_RUN_RESET = 1'b0;

    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_LIT = 4'h1,
        OP_CMP_EQ = 4'h2,
        OP_CMP_GT = 4'h3,
        OP_CMP_LT = 4'h4,
        OP_DEC_Z = 4'h5,
        OP_DEC_NZ = 4'h6,
        OP_INC_Z = 4'h7,
        OP_MUL = 4'h8,
        OP_BIT_SET = 4'h9,
        OP_BIT_CLR = 4'hA,
        OP_MOVE = 4'hB,
        OP_GOTO = 4'hC,
        OP_CALL = 4'hD,
        OP_RET = 4'hE,
        OP_BRA = 4'hF
    } mcudec_op_e;
endpackage
`default_nettype wire

//--- logic/mcudec_stack.sv
`default_nettype none
module mcudec_stack (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic push_in,
    input wire logic pop_in,
    input wire logic [20:0] push_data_in,
    output logic [20:0] top_out
);
    import mcudec_pkg::*;

    typedef struct packed {
        logic [STACK_DEPTH-1:0][20:0] mem;
        logic [2:0] ptr;
    } mcudec_stack_s;

    mcudec_stack_s s_q;
    mcudec_stack_s s_d;

    // Return address sits one below the pointer; wraps silently on overflow
    assign top_out = s_q.mem[s_q.ptr - 3'h1];

    // Push and pop never coincide: one control instruction per cycle
    always_comb begin
        s_d = s_q;
        if (push_in) begin
            s_d.mem[s_q.ptr] = push_data_in;
            s_d.ptr = s_q.ptr + 3'h1;
        end else if (pop_in) begin
            s_d.ptr = s_q.ptr - 3'h1;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule
`default_nettype wire
